// file: logic/lsrse_core.sv
// Purpose: Executes idle, literal load, option load, literal return, sleep,
//          rotate left through carry and subtract on an 8-bit core state
// Assumes: Instructions are issued by bus writes to the instruction register
// Notes: Every bus transfer inserts wait states; see the hand-over timing
`timescale 1ns/100ps

// How it works
// RULE1 - A load-literal instruction puts its 8-bit literal in the accumulator and touches no flag.
// RULE2 - A load-option instruction copies the accumulator into the option register and touches no flag.
// RULE3 - A return-with-literal instruction puts its 8-bit literal in the accumulator and touches no flag.
// RULE4 - A return-with-literal instruction reloads the program counter from the stack top.
// RULE5 - A return-with-literal instruction occupies two instruction cycles.
// RULE6 - A sleep instruction sets the watchdog expiry flag to one.
// RULE7 - A sleep instruction clears the power-down flag to zero.
// RULE8 - A sleep instruction clears the watchdog counter and its prescaler.
// RULE9 - After those updates a sleep instruction halts the core with the oscillator stopped.
// RULE10 - Rotate left moves the old carry into bit 0 and old bit 7 into carry, changing only carry.
// RULE11 - Rotate left sends its result to the accumulator when d is 0 and to the file register when d is 1.
// RULE12 - Subtract forms file register minus accumulator in two's complement and updates carry, half carry and zero.
// RULE13 - Subtract sends its result to the accumulator when d is 0 and to the file register when d is 1.
// RULE14 - The idle instruction takes one cycle and only advances the program counter.
module lsrse_core
  import lsrse_pkg::*;
#(
  parameter int FILE_DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic wake_req,
  output logic osc_stop,
  output logic [LSRSE_DATA_W-1:0] option_out
);

  lsrse_state_t s;
  lsrse_state_t next_s;
  lsrse_mem_req_t mem_req;
  logic [LSRSE_DATA_W-1:0] mem_rdata;
  logic accept;
  logic core_busy;
  lsrse_instr_t dec;
  logic [LSRSE_DATA_W-1:0] result;
  logic [LSRSE_DATA_W:0] diff;
  logic [4:0] nib;

  lsrse_file_mem #(
    .DEPTH(FILE_DEPTH)
  ) u_file_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  assign accept = hsel && htrans[1] && hready;
  assign core_busy = (s.ex == EX_OPER) || (s.ex == EX_RET2);

  // Instruction word decode
  always_comb begin
    dec.op = lsrse_op_t'(hwdata[LSRSE_INSTR_OP_LSB +: 3]);
    dec.d = hwdata[LSRSE_INSTR_D_BIT];
    dec.f = hwdata[LSRSE_INSTR_F_LSB +: LSRSE_FILE_AW];
    dec.k = hwdata[LSRSE_INSTR_K_LSB +: LSRSE_DATA_W];
  end

  always_comb begin
    next_s = s;
    mem_req = '0;
    result = '0;
    diff = '0;
    nib = '0;

    // Watchdog keeps its own count, also while asleep
    next_s.pre = s.pre + 8'h01;
    if (&s.pre) begin
      next_s.wdt = s.wdt + 8'h01;
    end

    // Second step of multi-cycle instructions, and wait for wake while asleep
    case (s.ex)
      EX_OPER: begin
        if (s.instr.op == OP_ROT_LEFT) begin
          result = {mem_rdata[6:0], s.c}; // [RULE10]
          next_s.c = mem_rdata[7]; // [RULE10]
        end else begin
          diff = {1'b0, mem_rdata} + {1'b0, ~s.acc} + 9'h001; // [RULE12]
          nib = {1'b0, mem_rdata[3:0]} + {1'b0, ~s.acc[3:0]} + 5'h01;
          result = diff[LSRSE_DATA_W-1:0];
          next_s.c = diff[LSRSE_DATA_W]; // [RULE12]
          next_s.dc = nib[4]; // [RULE12]
          next_s.z = (result == 8'h00); // [RULE12]
        end
        if (s.instr.d) begin
          mem_req.wen = 1'b1; // [RULE11] [RULE13]
          mem_req.addr = s.instr.f;
          mem_req.wdata = result;
        end else begin
          next_s.acc = result; // [RULE11] [RULE13]
        end
        next_s.pc = s.pc + LSRSE_PC_STEP;
        next_s.ex = EX_IDLE;
      end
      EX_RET2: begin
        next_s.ex = EX_IDLE; // [RULE5]
      end
      EX_SLEEP: begin
        if (wake_req) begin
          next_s.ex = EX_IDLE;
        end
      end
      default: begin
      end
    endcase

    // Bus data phase
    case (s.dp)
      DP_FIRST: begin
        if (!core_busy) begin
          next_s.dp = DP_DONE;
          if (s.ap_addr[LSRSE_FILE_SEL_BIT]) begin
            mem_req.addr = s.ap_addr[2 +: LSRSE_FILE_AW];
            if (s.ap_write) begin
              mem_req.wen = 1'b1;
              mem_req.wdata = hwdata[LSRSE_DATA_W-1:0];
            end else begin
              next_s.dp = DP_MEM;
            end
          end else if (s.ap_write) begin
            case (s.ap_addr)
              LSRSE_OFS_INSTR: begin
                if (s.ex != EX_SLEEP) begin
                  next_s.instr = dec;
                  case (dec.op)
                    OP_LOAD_LIT: begin
                      next_s.acc = dec.k; // [RULE1]
                      next_s.pc = s.pc + LSRSE_PC_STEP;
                    end
                    OP_LOAD_OPT: begin
                      next_s.option = s.acc; // [RULE2]
                      next_s.pc = s.pc + LSRSE_PC_STEP;
                    end
                    OP_RET_LIT: begin
                      next_s.acc = dec.k; // [RULE3]
                      next_s.pc = s.stack_top; // [RULE4]
                      next_s.ex = EX_RET2; // [RULE5]
                    end
                    OP_SLEEP: begin
                      next_s.to = 1'b1; // [RULE6]
                      next_s.pd = 1'b0; // [RULE7]
                      next_s.wdt = 8'h00; // [RULE8]
                      next_s.pre = 8'h00; // [RULE8]
                      next_s.pc = s.pc + LSRSE_PC_STEP;
                      next_s.ex = EX_SLEEP; // [RULE9]
                    end
                    OP_ROT_LEFT, OP_SUB: begin
                      mem_req.addr = dec.f;
                      next_s.ex = EX_OPER;
                    end
                    default: begin
                      next_s.pc = s.pc + LSRSE_PC_STEP; // [RULE14]
                    end
                  endcase
                end
              end
              LSRSE_OFS_ACC: begin
                next_s.acc = hwdata[LSRSE_DATA_W-1:0];
              end
              LSRSE_OFS_STATUS: begin
                next_s.c = hwdata[LSRSE_ST_C_BIT];
                next_s.dc = hwdata[LSRSE_ST_DC_BIT];
                next_s.z = hwdata[LSRSE_ST_Z_BIT];
              end
              LSRSE_OFS_PC: begin
                next_s.pc = hwdata[LSRSE_PC_W-1:0];
              end
              LSRSE_OFS_STACK_TOP: begin
                next_s.stack_top = hwdata[LSRSE_PC_W-1:0];
              end
              default: begin
              end
            endcase
          end else begin
            next_s.hrdata = 32'h0000_0000;
            case (s.ap_addr)
              LSRSE_OFS_INSTR: begin
                next_s.hrdata[LSRSE_INSTR_K_LSB +: LSRSE_DATA_W] = s.instr.k;
                next_s.hrdata[LSRSE_INSTR_F_LSB +: LSRSE_FILE_AW] = s.instr.f;
                next_s.hrdata[LSRSE_INSTR_D_BIT] = s.instr.d;
                next_s.hrdata[LSRSE_INSTR_OP_LSB +: 3] = s.instr.op;
              end
              LSRSE_OFS_ACC: begin
                next_s.hrdata[LSRSE_DATA_W-1:0] = s.acc;
              end
              LSRSE_OFS_STATUS: begin
                next_s.hrdata[LSRSE_ST_C_BIT] = s.c;
                next_s.hrdata[LSRSE_ST_DC_BIT] = s.dc;
                next_s.hrdata[LSRSE_ST_Z_BIT] = s.z;
                next_s.hrdata[LSRSE_ST_PD_BIT] = s.pd;
                next_s.hrdata[LSRSE_ST_TO_BIT] = s.to;
                next_s.hrdata[LSRSE_ST_BUSY_BIT] = core_busy;
                next_s.hrdata[LSRSE_ST_ASLEEP_BIT] = (s.ex == EX_SLEEP);
              end
              LSRSE_OFS_OPTION: begin
                next_s.hrdata[LSRSE_DATA_W-1:0] = s.option;
              end
              LSRSE_OFS_PC: begin
                next_s.hrdata[LSRSE_PC_W-1:0] = s.pc;
              end
              LSRSE_OFS_STACK_TOP: begin
                next_s.hrdata[LSRSE_PC_W-1:0] = s.stack_top;
              end
              LSRSE_OFS_WDT: begin
                next_s.hrdata[LSRSE_DATA_W-1:0] = s.wdt;
              end
              default: begin
              end
            endcase
          end
        end
      end
      DP_MEM: begin
        next_s.hrdata = {24'h00_0000, mem_rdata};
        next_s.dp = DP_DONE;
      end
      default: begin
        next_s.dp = DP_NONE;
      end
    endcase

    // Address phase capture
    if (accept) begin
      next_s.ap_write = hwrite;
      next_s.ap_addr = haddr[7:0];
      next_s.dp = DP_FIRST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.dp <= DP_NONE;
      s.ex <= EX_IDLE;
      s.to <= LSRSE_RST_TO;
      s.pd <= LSRSE_RST_PD;
      s.pc <= LSRSE_RST_PC;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Clock enable low also stalls the bus
  assign hreadyout = ce && ((s.dp == DP_NONE) || (s.dp == DP_DONE));
  assign hrdata = s.hrdata;
  assign hresp = 1'b0;
  assign osc_stop = (s.ex == EX_SLEEP); // [RULE9]
  assign option_out = s.option;

endmodule // lsrse_core

// file: logic/lsrse_pkg.sv
// Purpose: Shared constants and types for the instruction execution block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Bus offsets are byte addresses inside the slave window
package lsrse_pkg;

  localparam int LSRSE_DATA_W = 8;
  localparam int LSRSE_PC_W = 11;
  localparam int LSRSE_PRE_W = 8;
  localparam int LSRSE_FILE_AW = 5;

  // Register offsets
  localparam logic [7:0] LSRSE_OFS_INSTR = 8'h00;
  localparam logic [7:0] LSRSE_OFS_ACC = 8'h04;
  localparam logic [7:0] LSRSE_OFS_STATUS = 8'h08;
  localparam logic [7:0] LSRSE_OFS_OPTION = 8'h0C;
  localparam logic [7:0] LSRSE_OFS_PC = 8'h10;
  localparam logic [7:0] LSRSE_OFS_STACK_TOP = 8'h14;
  localparam logic [7:0] LSRSE_OFS_WDT = 8'h18;
  localparam int LSRSE_FILE_SEL_BIT = 7;

  // Instruction word fields
  localparam int LSRSE_INSTR_K_LSB = 0;
  localparam int LSRSE_INSTR_F_LSB = 8;
  localparam int LSRSE_INSTR_D_BIT = 13;
  localparam int LSRSE_INSTR_OP_LSB = 16;

  // Status fields
  localparam int LSRSE_ST_C_BIT = 0;
  localparam int LSRSE_ST_DC_BIT = 1;
  localparam int LSRSE_ST_Z_BIT = 2;
  localparam int LSRSE_ST_PD_BIT = 3;
  localparam int LSRSE_ST_TO_BIT = 4;
  localparam int LSRSE_ST_BUSY_BIT = 8;
  localparam int LSRSE_ST_ASLEEP_BIT = 9;

  // Reset values
  localparam logic LSRSE_RST_TO = 1'b1;
  localparam logic LSRSE_RST_PD = 1'b1;
  localparam logic [LSRSE_PC_W-1:0] LSRSE_RST_PC = 11'h000;
  localparam logic [LSRSE_PC_W-1:0] LSRSE_PC_STEP = 11'h001;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_LOAD_LIT,
    OP_LOAD_OPT,
    OP_RET_LIT,
    OP_SLEEP,
    OP_ROT_LEFT,
    OP_SUB
  } lsrse_op_t;

  typedef enum logic [1:0] {
    EX_IDLE,
    EX_OPER,
    EX_RET2,
    EX_SLEEP
  } lsrse_ex_t;

  typedef enum logic [1:0] {
    DP_NONE,
    DP_FIRST,
    DP_MEM,
    DP_DONE
  } lsrse_dp_t;

  typedef struct packed {
    lsrse_op_t op;
    logic d;
    logic [LSRSE_FILE_AW-1:0] f;
    logic [LSRSE_DATA_W-1:0] k;
  } lsrse_instr_t;

  typedef struct packed {
    logic wen;
    logic [LSRSE_FILE_AW-1:0] addr;
    logic [LSRSE_DATA_W-1:0] wdata;
  } lsrse_mem_req_t;

  typedef struct packed {
    logic ap_write;
    logic [7:0] ap_addr;
    lsrse_dp_t dp;
    lsrse_ex_t ex;
    logic [31:0] hrdata;
    lsrse_instr_t instr;
    logic [LSRSE_DATA_W-1:0] acc;
    logic [LSRSE_DATA_W-1:0] option;
    logic c;
    logic dc;
    logic z;
    logic to;
    logic pd;
    logic [LSRSE_PC_W-1:0] pc;
    logic [LSRSE_PC_W-1:0] stack_top;
    logic [LSRSE_DATA_W-1:0] wdt;
    logic [LSRSE_PRE_W-1:0] pre;
  } lsrse_state_t;

endpackage

// file: logic/lsrse_file_mem.sv
// Purpose: File register array with one port and registered read data
// Assumes: Read data appear one enabled clock after the address
// Notes: A write in the same cycle returns the old contents
`timescale 1ns/100ps
module lsrse_file_mem
  import lsrse_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input lsrse_mem_req_t req,
  output logic [LSRSE_DATA_W-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][LSRSE_DATA_W-1:0] cells;
    logic [LSRSE_DATA_W-1:0] rdata;
  } lsrse_mem_state_t;

  lsrse_mem_state_t s;
  lsrse_mem_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.rdata = s.cells[req.addr];
    if (req.wen) begin
      next_s.cells[req.addr] = req.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;

endmodule // lsrse_file_mem

// file: tb/lsrse_properties.sv
// Purpose: Port checks for the execution block
// Assumes: hready is tied to hreadyout
// Notes: Tracks the pending data phase
`timescale 1ns/100ps
module lsrse_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic wake_req,
  input wire logic osc_stop,
  input wire logic [7:0] option_out
);
  logic pend;
  logic wr0;
  wire logic take = hsel && htrans[1] && hready && ce;
  wire logic done = pend && hreadyout;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      wr0 <= 1'b0;
    end else if (take) begin
      pend <= 1'b1;
      wr0 <= hwrite && haddr[7:0] == 8'h00;
    end else if (done) begin
      pend <= 1'b0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_instr(logic [2:0] c);
    done && wr0 && hwdata[18:16] == c;
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  chk_ready_ce: assert property (!ce |-> !hreadyout) else $error("ready while clock disabled");
  chk_wait_state: assert property (take |=> !hreadyout) else $error("no wait state");
  chk_answer_bound: assert property (take |-> ##[1:8] hreadyout) else $error("transfer hangs");
  chk_sleep_enter: assert property (s_instr(3'h4) |-> osc_stop)
    else $error("sleep did not stop oscillator");
  chk_sleep_hold: assert property (osc_stop && !wake_req |=> osc_stop)
    else $error("left sleep without wake");
  chk_osc_cause: assert property ($rose(osc_stop) |-> pend && wr0 && hwdata[18:16] == 3'h4)
    else $error("oscillator stopped without sleep");
  chk_option_cause: assert property ($changed(option_out) |-> pend && wr0 && hwdata[18:16] == 3'h2)
    else $error("option changed without load");
  chk_wake_exit: assert property (osc_stop && wake_req && ce |-> ##[1:2] !osc_stop) else $error("wake ignored");
endmodule // lsrse_props

bind lsrse_core lsrse_props lsrse_props_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .wake_req(wake_req), .osc_stop(osc_stop), .option_out(option_out));

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the execution block
// Assumes: Single AHB-Lite master, hready tied to hreadyout
// Notes: Instructions issued by writes to the instruction register
`timescale 1ns/100ps
module tb_top;
  import lsrse_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic wake_req = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, osc_stop;
  logic [31:0] hrdata, rd;
  logic [7:0] option_out;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  lsrse_core lsrse_core_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wake_req(wake_req), .osc_stop(osc_stop),
    .option_out(option_out));
  initial forever #12.5 hclk = ~hclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic ex(input logic [2:0] op, input logic d, input logic [4:0] f, input logic [7:0] k);
    bus(1'b1, LSRSE_OFS_INSTR, {13'h0, op, 2'b0, d, f, k});
  endtask
  task automatic t_reset;
    ce <= 1'b0;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    rdchk(LSRSE_OFS_STATUS, 32'h18);
    rdchk(LSRSE_OFS_PC, 32'h0);
    rdchk(8'h40, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_literal;
    bus(1'b1, LSRSE_OFS_STATUS, 32'h1);
    ex(3'h1, 1'b0, 5'h0, 8'hFF);
    rdchk(LSRSE_OFS_ACC, 32'hFF);
    rdchk(LSRSE_OFS_STATUS, 32'h19);
    ex(3'h0, 1'b1, 5'h1F, 8'h12);
    rdchk(LSRSE_OFS_ACC, 32'hFF);
    rdchk(LSRSE_OFS_STATUS, 32'h19);
    rdchk(LSRSE_OFS_PC, 32'h2);
    ex(3'h1, 1'b0, 5'h0, 8'hA5);
    ex(3'h2, 1'b0, 5'h0, 8'h00);
    rdchk(LSRSE_OFS_STATUS, 32'h19);
    chk({24'h0, option_out}, 32'hA5);
    $display("literal test done");
  endtask
  task automatic t_return;
    bus(1'b1, LSRSE_OFS_STACK_TOP, 32'h5A5);
    ex(3'h3, 1'b0, 5'h0, 8'h3C);
    rdchk(LSRSE_OFS_ACC, 32'h3C);
    rdchk(LSRSE_OFS_PC, 32'h5A5);
    rdchk(LSRSE_OFS_STATUS, 32'h19);
    $display("return test done");
  endtask
  task automatic t_rotate;
    bus(1'b1, 8'h8C, 32'h81);
    bus(1'b1, LSRSE_OFS_STATUS, 32'h6);
    ex(3'h5, 1'b0, 5'h3, 8'h00);
    rdchk(LSRSE_OFS_ACC, 32'h02);
    rdchk(8'h8C, 32'h81);
    rdchk(LSRSE_OFS_STATUS, 32'h1F);
    ex(3'h5, 1'b1, 5'h3, 8'h00);
    rdchk(8'h8C, 32'h03);
    rdchk(LSRSE_OFS_ACC, 32'h02);
    rdchk(LSRSE_OFS_STATUS, 32'h1F);
    $display("rotate test done");
  endtask
  task automatic t_sub;
    logic [7:0] fv [3] = '{8'h10, 8'h05, 8'h01};
    logic [7:0] wv [3] = '{8'h01, 8'h05, 8'h02};
    logic [7:0] r;
    logic d;
    for (int i = 0; i < 3; i++) begin
      d = ~i[0];
      r = fv[i] - wv[i];
      bus(1'b1, 8'h9C, {24'h0, fv[i]});
      bus(1'b1, LSRSE_OFS_ACC, {24'h0, wv[i]});
      ex(3'h6, d, 5'h7, 8'h00);
      rdchk(8'h9C, {24'h0, d ? r : fv[i]});
      rdchk(LSRSE_OFS_ACC, {24'h0, d ? wv[i] : r});
      rdchk(LSRSE_OFS_STATUS, {29'h3, r == 8'h0, fv[i][3:0] >= wv[i][3:0], fv[i] >= wv[i]});
    end
    $display("subtract test done");
  endtask
  task automatic t_sleep;
    repeat (300) @(posedge hclk);
    bus(1'b0, LSRSE_OFS_WDT, 32'h0);
    chk({31'h0, rd[7:0] != 8'h00}, 32'h1);
    ex(3'h4, 1'b0, 5'h0, 8'h00);
    chk({31'h0, osc_stop}, 32'h1);
    rdchk(LSRSE_OFS_STATUS, 32'h210);
    repeat (200) @(posedge hclk);
    rdchk(LSRSE_OFS_WDT, 32'h0);
    ex(3'h1, 1'b0, 5'h0, 8'h77);
    rdchk(LSRSE_OFS_ACC, 32'h02);
    repeat (100) @(posedge hclk);
    rdchk(LSRSE_OFS_WDT, 32'h1);
    wake_req <= 1'b1;
    repeat (3) @(posedge hclk);
    wake_req <= 1'b0;
    chk({31'h0, osc_stop}, 32'h0);
    $display("sleep test done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_literal();
    t_return();
    t_rotate();
    t_sub();
    t_sleep();
    end_sim();
  end
endmodule // tb_top
